// File: shared/ptoc_pkg.sv
`default_nettype none
package ptoc_pkg;
  // sizes
  localparam int          DATA_W        = 32;
  localparam int          ADDR_W        = 8;
  localparam int          CH_N          = 4;
  localparam int          CTRL_W        = 2;
  // address fields
  localparam int          REG_LSB       = 2;
  localparam int          REG_MSB       = 4;
  localparam int          CH_LSB        = 5;
  localparam int          CH_MSB        = 6;
  // register index inside a channel window
  localparam logic [2:0]  REG_CTRL      = 3'h0;
  localparam logic [2:0]  REG_PERIOD    = 3'h1;
  localparam logic [2:0]  REG_WIDTH     = 3'h2;
  localparam logic [2:0]  REG_DELAY     = 3'h3;
  localparam logic [2:0]  REG_COUNT     = 3'h4;
  localparam logic [2:0]  REG_STATUS    = 3'h5;
  localparam logic [2:0]  REG_PULSES    = 3'h6;
  // field positions
  localparam int          CTRL_EN_BIT   = 0;
  localparam int          CTRL_INV_BIT  = 1;
  localparam int          STAT_RUN_BIT  = 0;
  localparam int          STAT_DONE_BIT = 1;
  // reset values
  localparam logic [1:0]  CTRL_RST      = 2'h0;
  localparam logic [31:0] PERIOD_RST    = 32'h0000_0002;
  localparam logic [31:0] WIDTH_RST     = 32'h0000_0001;
  localparam logic [31:0] DELAY_RST     = 32'h0000_0000;
  localparam logic [31:0] COUNT_RST     = 32'h0000_0000;
  // bus answers
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_DECERR   = 2'h3;
  // timing
  localparam int          CLK_HZ        = 10_000_000;
  localparam int          CLK_PERIOD_NS = 100;
  localparam int          MIN_TIME_PS   = 20_830;
  localparam int          MAX_TIME_MS   = 44_739;
  localparam logic [31:0] MIN_TIME_CYC  =
    32'((MIN_TIME_PS + CLK_PERIOD_NS * 1000 - 1) / (CLK_PERIOD_NS * 1000));
  localparam logic [31:0] MAX_TIME_CYC  = 32'(MAX_TIME_MS * (CLK_HZ / 1000));
  // channel states
  typedef enum logic [1:0] {
    PTOC_IDLE,
    PTOC_DELAY,
    PTOC_RUN,
    PTOC_DONE
  } ptoc_state_t;
endpackage
`default_nettype wire

// File: shared/ptoc_chan_if.sv
`timescale 1ns/1ns
`default_nettype none
interface ptoc_chan_if;
  logic        en;
  logic        inv;
  logic [31:0] period;
  logic [31:0] width;
  logic [31:0] delay;
  logic [31:0] count;
  logic        pulse_out;
  logic        running;
  logic        done;
  logic [31:0] pulses;
  modport ctl (output en, inv, period, width, delay, count,
               input  pulse_out, running, done, pulses);
  modport chan (input  en, inv, period, width, delay, count,
                output pulse_out, running, done, pulses);
endinterface
`default_nettype wire

// File: logic/ptoc_channel.sv
`timescale 1ns/1ns
`default_nettype none
module ptoc_channel #(
  parameter logic [31:0] MAX_CYC = ptoc_pkg::MAX_TIME_CYC
) (
  input wire logic   aclk,
  input wire logic   aresetn,
  ptoc_chan_if.chan  c
);
  ptoc_pkg::ptoc_state_t st_q, st_d;
  logic [31:0] cnt_q, cnt_d;
  logic [31:0] pul_q, pul_d;
  logic        out_q;

  // clamp period into the supported span; delay is only capped at its upper end
  wire [31:0] per_lim = (c.period > MAX_CYC) ? MAX_CYC : c.period;
  wire [31:0] per_eff = (per_lim < ptoc_pkg::MIN_TIME_CYC) ?
                        ptoc_pkg::MIN_TIME_CYC : per_lim;
  wire [31:0] per_m1  = per_eff - 32'h0000_0001;
  wire [31:0] dly_lim = (c.delay > MAX_CYC) ? MAX_CYC : c.delay;
  wire [31:0] dly_m1  = dly_lim - 32'h0000_0001;
  wire        wrap    = cnt_q >= per_m1;
  wire        last    = (c.count != 32'h0000_0000) &&
                        (pul_q + 32'h0000_0001 >= c.count);
  wire        active  = (st_q == ptoc_pkg::PTOC_RUN) && (cnt_q < c.width);

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    pul_d = pul_q;
    case (st_q)
      ptoc_pkg::PTOC_IDLE: begin
        if (c.en) begin
          cnt_d = 32'h0000_0000;
          pul_d = 32'h0000_0000;
          st_d  = (dly_lim == 32'h0000_0000) ? ptoc_pkg::PTOC_RUN : ptoc_pkg::PTOC_DELAY;
        end
      end
      ptoc_pkg::PTOC_DELAY: begin
        if (!c.en) begin
          st_d = ptoc_pkg::PTOC_IDLE;
        end else if ((cnt_q >= dly_m1) || (dly_lim == 32'h0000_0000)) begin
          cnt_d = 32'h0000_0000;
          st_d  = ptoc_pkg::PTOC_RUN;
        end else begin
          cnt_d = cnt_q + 32'h0000_0001;
        end
      end
      ptoc_pkg::PTOC_RUN: begin
        if (!c.en) begin
          st_d = ptoc_pkg::PTOC_IDLE;
        end else if (wrap) begin
          cnt_d = 32'h0000_0000;
          pul_d = pul_q + 32'h0000_0001;
          if (last) begin
            st_d = ptoc_pkg::PTOC_DONE;
          end
        end else begin
          cnt_d = cnt_q + 32'h0000_0001;
        end
      end
      ptoc_pkg::PTOC_DONE: begin
        if (!c.en) begin
          st_d = ptoc_pkg::PTOC_IDLE;
        end
      end
      default: st_d = ptoc_pkg::PTOC_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q  <= ptoc_pkg::PTOC_IDLE;
      cnt_q <= 32'h0000_0000;
      pul_q <= 32'h0000_0000;
      out_q <= 1'b0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      pul_q <= pul_d;
      out_q <= c.inv ^ active;
    end
  end

  assign c.pulse_out = out_q;
  assign c.running   = (st_q == ptoc_pkg::PTOC_DELAY) || (st_q == ptoc_pkg::PTOC_RUN);
  assign c.done      = (st_q == ptoc_pkg::PTOC_DONE);
  assign c.pulses    = pul_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_rest_off;
    !c.en [*2] |=> c.pulse_out == $past(c.inv);
  endproperty
  a_rest_off: assert property (p_rest_off) else $error("output not resting while off");

  property p_delay_rest;
    (st_q == ptoc_pkg::PTOC_IDLE) && c.en && (dly_lim >= 32'h0000_0002)
      |=> ##1 (c.pulse_out == $past(c.inv)) [*2];
  endproperty
  a_delay_rest: assert property (p_delay_rest) else $error("pulse during start delay");

  property p_first_high;
    (st_q == ptoc_pkg::PTOC_RUN) && (cnt_q == 32'h0000_0000) && (c.width != 32'h0000_0000)
      |=> c.pulse_out != $past(c.inv);
  endproperty
  a_first_high: assert property (p_first_high) else $error("pulse missing at period start");

  property p_stop_count;
    (st_q == ptoc_pkg::PTOC_RUN) && c.en && wrap && last
      |=> (st_q == ptoc_pkg::PTOC_DONE) ##1 (c.pulse_out == $past(c.inv));
  endproperty
  a_stop_count: assert property (p_stop_count) else $error("pulses beyond programmed count");

  property p_wrap;
    (st_q == ptoc_pkg::PTOC_RUN) && c.en && wrap |=> cnt_q == 32'h0000_0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("period count not restarted");

  property p_endless;
    (st_q == ptoc_pkg::PTOC_RUN) && c.en && (c.count == 32'h0000_0000)
      |=> st_q == ptoc_pkg::PTOC_RUN;
  endproperty
  a_endless: assert property (p_endless) else $error("zero count run stopped");

  property p_span;
    (per_eff >= ptoc_pkg::MIN_TIME_CYC) && (cnt_q < MAX_CYC);
  endproperty
  a_span: assert property (p_span) else $error("timing outside span");

  c_done: cover property (st_q == ptoc_pkg::PTOC_RUN ##1 st_q == ptoc_pkg::PTOC_DONE);
  c_delay_run: cover property (st_q == ptoc_pkg::PTOC_DELAY ##1 st_q == ptoc_pkg::PTOC_RUN);
endmodule // ptoc_channel
`default_nettype wire

// File: logic/ptoc_top.sv
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - four independent channels, each with its own pin and 32-bit settings
// - pulse frequency programmable across the whole supported range
// - period clamped to the supported span; start delay only capped at its upper end
// - high time set by width; duty equals width over period
// - a nonzero count stops the channel after that many pulses; count 0 runs without end
// - after enable, output rests for the delay before first pulse
// - selectable resting level held whenever no pulse is driven
// - period and width may change while running without stopping
// - separate count, period, delay and width settings per channel
// - default rest low with high pulses; invert swaps both levels
module ptoc_top #(
  parameter logic [31:0] MAX_TIME_CYC = ptoc_pkg::MAX_TIME_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             pulse_out_0,
  output logic             pulse_out_1,
  output logic             pulse_out_2,
  output logic             pulse_out_3
);
  localparam int N = ptoc_pkg::CH_N;

  // settings per channel
  logic [1:0]  ctrl_q [N];
  logic [31:0] per_q  [N];
  logic [31:0] wid_q  [N];
  logic [31:0] dly_q  [N];
  logic [31:0] cnt_q  [N];

  // status from channels
  logic        run_w  [N];
  logic        done_w [N];
  logic [31:0] pul_w  [N];
  logic        pin_w  [N];

  // write channel holding registers
  logic        aw_have_q;
  logic        w_have_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;

  // read channel registers
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // handshake readies
  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready  = !w_have_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take  = s_axi_wvalid && s_axi_wready;
  wire ar_take = s_axi_arvalid && s_axi_arready;

  // write decode
  wire [1:0] wr_ch    = awaddr_q[ptoc_pkg::CH_MSB:ptoc_pkg::CH_LSB];
  wire [2:0] wr_reg   = awaddr_q[ptoc_pkg::REG_MSB:ptoc_pkg::REG_LSB];
  wire       wr_inmap = !awaddr_q[ptoc_pkg::ADDR_W-1] && (wr_reg <= ptoc_pkg::REG_PULSES);
  wire       wr_ok    = wr_inmap && (wr_reg <= ptoc_pkg::REG_COUNT);
  wire       wr_fire  = aw_have_q && w_have_q && !bvalid_q;

  // read decode
  wire [1:0] rd_ch    = s_axi_araddr[ptoc_pkg::CH_MSB:ptoc_pkg::CH_LSB];
  wire [2:0] rd_reg   = s_axi_araddr[ptoc_pkg::REG_MSB:ptoc_pkg::REG_LSB];
  wire       rd_inmap = !s_axi_araddr[ptoc_pkg::ADDR_W-1] && (rd_reg <= ptoc_pkg::REG_PULSES);

  logic [31:0] ctrl_word;
  logic [31:0] stat_word;
  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[ptoc_pkg::CTRL_W-1:0] = ctrl_q[rd_ch];
    stat_word = 32'h0000_0000;
    stat_word[ptoc_pkg::STAT_RUN_BIT]  = run_w[rd_ch];
    stat_word[ptoc_pkg::STAT_DONE_BIT] = done_w[rd_ch];
  end

  wire [31:0] rd_word =
    !rd_inmap                         ? 32'h0000_0000 :
    (rd_reg == ptoc_pkg::REG_CTRL)    ? ctrl_word :
    (rd_reg == ptoc_pkg::REG_PERIOD)  ? per_q[rd_ch] :
    (rd_reg == ptoc_pkg::REG_WIDTH)   ? wid_q[rd_ch] :
    (rd_reg == ptoc_pkg::REG_DELAY)   ? dly_q[rd_ch] :
    (rd_reg == ptoc_pkg::REG_COUNT)   ? cnt_q[rd_ch] :
    (rd_reg == ptoc_pkg::REG_STATUS)  ? stat_word :
    pul_w[rd_ch];

  // write address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      awaddr_q  <= 8'h00;
    end else if (aw_take) begin
      aw_have_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (w_take) begin
      w_have_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= ptoc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_inmap ? ptoc_pkg::RESP_OKAY : ptoc_pkg::RESP_DECERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // read answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= ptoc_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= rd_inmap ? ptoc_pkg::RESP_OKAY : ptoc_pkg::RESP_DECERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // settings store; running channels pick up new values at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < N; i++) begin
        ctrl_q[i] <= ptoc_pkg::CTRL_RST;
        per_q[i]  <= ptoc_pkg::PERIOD_RST;
        wid_q[i]  <= ptoc_pkg::WIDTH_RST;
        dly_q[i]  <= ptoc_pkg::DELAY_RST;
        cnt_q[i]  <= ptoc_pkg::COUNT_RST;
      end
    end else if (wr_fire && wr_ok) begin
      case (wr_reg)
        ptoc_pkg::REG_CTRL: begin
          if (wstrb_q[0]) begin
            ctrl_q[wr_ch] <= wdata_q[ptoc_pkg::CTRL_W-1:0];
          end
        end
        ptoc_pkg::REG_PERIOD: per_q[wr_ch] <= merge(per_q[wr_ch], wdata_q, wstrb_q);
        ptoc_pkg::REG_WIDTH:  wid_q[wr_ch] <= merge(wid_q[wr_ch], wdata_q, wstrb_q);
        ptoc_pkg::REG_DELAY:  dly_q[wr_ch] <= merge(dly_q[wr_ch], wdata_q, wstrb_q);
        ptoc_pkg::REG_COUNT:  cnt_q[wr_ch] <= merge(cnt_q[wr_ch], wdata_q, wstrb_q);
        default: ;
      endcase
    end
  end

  // one timer per channel
  for (genvar g = 0; g < N; g++) begin : g_ch
    ptoc_chan_if cif ();
    assign cif.en     = ctrl_q[g][ptoc_pkg::CTRL_EN_BIT];
    assign cif.inv    = ctrl_q[g][ptoc_pkg::CTRL_INV_BIT];
    assign cif.period = per_q[g];
    assign cif.width  = wid_q[g];
    assign cif.delay  = dly_q[g];
    assign cif.count  = cnt_q[g];
    assign run_w[g]   = cif.running;
    assign done_w[g]  = cif.done;
    assign pul_w[g]   = cif.pulses;
    assign pin_w[g]   = cif.pulse_out;
    ptoc_channel #(
      .MAX_CYC (MAX_TIME_CYC)
    ) u_chan (
      .aclk    (aclk),
      .aresetn (aresetn),
      .c       (cif)
    );
  end

  assign pulse_out_0 = pin_w[0];
  assign pulse_out_1 = pin_w[1];
  assign pulse_out_2 = pin_w[2];
  assign pulse_out_3 = pin_w[3];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_ch_indep;
    wr_fire && (wr_ch != 2'h0) |=> $stable(per_q[0]) && $stable(ctrl_q[0]) && $stable(wid_q[0]);
  endproperty
  a_ch_indep: assert property (p_ch_indep) else $error("write leaked into channel 0");

  property p_store;
    wr_fire && wr_ok && (wr_reg == ptoc_pkg::REG_DELAY) && (wstrb_q == 4'hf)
      |=> dly_q[$past(wr_ch)] == $past(wdata_q);
  endproperty
  a_store: assert property (p_store) else $error("delay setting not stored");

  property p_live;
    wr_fire && wr_ok && (wr_reg == ptoc_pkg::REG_PERIOD) && run_w[wr_ch]
      && ctrl_q[wr_ch][ptoc_pkg::CTRL_EN_BIT]
      |=> run_w[$past(wr_ch)] || done_w[$past(wr_ch)];
  endproperty
  a_live: assert property (p_live) else $error("period write stopped channel");

  property p_wr_answer;
    aw_take ##1 (w_have_q && !bvalid_q) |=> s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer missing");

  property p_rd_answer;
    ar_take |=> s_axi_rvalid && (s_axi_rresp == ($past(rd_inmap) ? ptoc_pkg::RESP_OKAY : ptoc_pkg::RESP_DECERR));
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer wrong");

  c_write: cover property (wr_fire && wr_ok ##1 s_axi_bvalid && s_axi_bready);
  c_read: cover property (ar_take ##1 s_axi_rvalid && s_axi_rready);
  c_pulse: cover property ($rose(pulse_out_0) ##[1:20] $fell(pulse_out_0));
endmodule // ptoc_top
`default_nettype wire

// File: testbench/ptoc_pin_load.sv
`timescale 1ns/1ns
`default_nettype none
// load on the four timer pins; tallies rising edges and high cycles per pin
module ptoc_pin_load (
  input  wire logic        aclk,
  input  wire logic        clr,
  input  wire logic [3:0]  pins,
  output logic [3:0][15:0] rises,
  output logic [3:0][15:0] highs
);
  logic [3:0] last_q;

  always_ff @(posedge aclk) begin
    last_q <= pins;
    for (int i = 0; i < 4; i++) begin
      if (clr) begin
        rises[i] <= 16'h0000;
        highs[i] <= 16'h0000;
      end else begin
        if (pins[i] && !last_q[i]) rises[i] <= rises[i] + 16'h0001;
        if (pins[i]) highs[i] <= highs[i] + 16'h0001;
      end
    end
  end
endmodule // ptoc_pin_load
`default_nettype wire

// File: testbench/tb_pwm_timer_output_channels.sv
`timescale 1ns/1ns
`default_nettype none
module tb_pwm_timer_output_channels;
  logic             aclk;
  logic             aresetn;
  logic [7:0]       awaddr;
  logic             awvalid;
  logic             awready;
  logic [31:0]      wdata;
  logic [3:0]       wstrb;
  logic             wvalid;
  logic             wready;
  logic [1:0]       bresp;
  logic             bvalid;
  logic             bready;
  logic [7:0]       araddr;
  logic             arvalid;
  logic             arready;
  logic [31:0]      rdata;
  logic [1:0]       rresp;
  logic             rvalid;
  logic             rready;
  wire logic [3:0]  pins;
  logic             clr;
  logic [3:0][15:0] rises;
  logic [3:0][15:0] highs;
  int               n_mismatch;
  int               check_count;

  ptoc_top #(.MAX_TIME_CYC(32'h0000_0040)) i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pulse_out_0(pins[0]), .pulse_out_1(pins[1]), .pulse_out_2(pins[2]), .pulse_out_3(pins[3])
  );

  ptoc_pin_load i_load (.aclk(aclk), .clr(clr), .pins(pins), .rises(rises), .highs(highs));

  task automatic stop_test;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_range(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    check_count++;
    if ($isunknown(got) || got < lo || got > hi) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  function automatic logic [7:0] ra(input int ch, input logic [2:0] r);
    return {1'b0, 2'(ch), r, 2'h0};
  endfunction

  // one write; response compared with e
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    check_word({30'h0, bresp}, {30'h0, e});
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    check_word(d, e);
    check_word({30'h0, r}, {30'h0, ptoc_pkg::RESP_OKAY});
  endtask

  task automatic clear_load;
    @(posedge aclk);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
  endtask

  task automatic t_reset;
    check_word({28'h0, pins}, 32'h0000_0000);
    rd_chk(ra(0, ptoc_pkg::REG_CTRL), {30'h0, ptoc_pkg::CTRL_RST});
    rd_chk(ra(0, ptoc_pkg::REG_PERIOD), ptoc_pkg::PERIOD_RST);
    rd_chk(ra(0, ptoc_pkg::REG_WIDTH), ptoc_pkg::WIDTH_RST);
    rd_chk(ra(0, ptoc_pkg::REG_DELAY), ptoc_pkg::DELAY_RST);
    rd_chk(ra(0, ptoc_pkg::REG_COUNT), ptoc_pkg::COUNT_RST);
    wr(ra(1, ptoc_pkg::REG_PERIOD), 32'hAABB_CCDD, 4'h3, ptoc_pkg::RESP_OKAY);
    rd_chk(ra(1, ptoc_pkg::REG_PERIOD), 32'h0000_CCDD);
  endtask

  task automatic t_unmapped;
    logic [31:0] d;
    logic [1:0]  r;
    rd(8'h80, d, r);
    check_word({30'h0, r}, {30'h0, ptoc_pkg::RESP_DECERR});
    check_word(d, 32'h0000_0000);
    rd(8'h1C, d, r);
    check_word({30'h0, r}, {30'h0, ptoc_pkg::RESP_DECERR});
    wr(8'h80, 32'h0000_0001, 4'hF, ptoc_pkg::RESP_DECERR);
    check_word({28'h0, pins}, 32'h0000_0000);
  endtask

  task automatic t_count_width;
    wr(ra(0, ptoc_pkg::REG_PERIOD), 32'h0000_0004, 4'hF, ptoc_pkg::RESP_OKAY);
    wr(ra(0, ptoc_pkg::REG_WIDTH), 32'h0000_0003, 4'hF, ptoc_pkg::RESP_OKAY);
    wr(ra(0, ptoc_pkg::REG_COUNT), 32'h0000_0002, 4'hF, ptoc_pkg::RESP_OKAY);
    clear_load();
    wr(ra(0, ptoc_pkg::REG_CTRL), 32'h0000_0001, 4'hF, ptoc_pkg::RESP_OKAY);
    repeat (30) @(posedge aclk);
    check_word({16'h0, rises[0]}, 32'h0000_0002);
    check_word({16'h0, highs[0]}, 32'h0000_0006);
    check_word({16'h0, rises[1] | rises[2] | rises[3]}, 32'h0000_0000);
    rd_chk(ra(0, ptoc_pkg::REG_STATUS), 32'h0000_0002);
    rd_chk(ra(0, ptoc_pkg::REG_PULSES), 32'h0000_0002);
  endtask

  task automatic t_delay;
    int n;
    wr(ra(1, ptoc_pkg::REG_PERIOD), 32'h0000_0005, 4'hF, ptoc_pkg::RESP_OKAY);
    wr(ra(1, ptoc_pkg::REG_WIDTH), 32'h0000_0002, 4'hF, ptoc_pkg::RESP_OKAY);
    wr(ra(1, ptoc_pkg::REG_DELAY), 32'h0000_0007, 4'hF, ptoc_pkg::RESP_OKAY);
    wr(ra(1, ptoc_pkg::REG_COUNT), 32'h0000_0001, 4'hF, ptoc_pkg::RESP_OKAY);
    wr(ra(1, ptoc_pkg::REG_CTRL), 32'h0000_0001, 4'hF, ptoc_pkg::RESP_OKAY);
    n = 0;
    while (pins[1] !== 1'b1 && n < 100) begin
      @(posedge aclk);
      n++;
    end
    check_word(32'(n), 32'h0000_0009);
    repeat (10) @(posedge aclk);
    rd_chk(ra(1, ptoc_pkg::REG_PULSES), 32'h0000_0001);
  endtask

  task automatic t_invert;
    logic [31:0] d;
    logic [1:0]  r;
    wr(ra(2, ptoc_pkg::REG_CTRL), 32'h0000_0002, 4'hF, ptoc_pkg::RESP_OKAY);
    repeat (3) @(posedge aclk);
    check_word({31'h0, pins[2]}, 32'h0000_0001);
    wr(ra(2, ptoc_pkg::REG_PERIOD), 32'h0000_0003, 4'hF, ptoc_pkg::RESP_OKAY);
    clear_load();
    wr(ra(2, ptoc_pkg::REG_CTRL), 32'h0000_0003, 4'hF, ptoc_pkg::RESP_OKAY);
    repeat (30) @(posedge aclk);
    check_range({16'h0, rises[2]}, 32'h0000_0008, 32'h0000_000B);
    rd_chk(ra(2, ptoc_pkg::REG_STATUS), 32'h0000_0001);
    rd(ra(2, ptoc_pkg::REG_PULSES), d, r);
    check_range(d, 32'h0000_0009, 32'h0000_000E);
    wr(ra(2, ptoc_pkg::REG_CTRL), 32'h0000_0002, 4'hF, ptoc_pkg::RESP_OKAY);
    repeat (3) @(posedge aclk);
    check_word({31'h0, pins[2]}, 32'h0000_0001);
    rd_chk(ra(2, ptoc_pkg::REG_STATUS), 32'h0000_0000);
  endtask

  task automatic t_clamp_live;
    wr(ra(3, ptoc_pkg::REG_PERIOD), 32'h0000_1000, 4'hF, ptoc_pkg::RESP_OKAY);
    clear_load();
    wr(ra(3, ptoc_pkg::REG_CTRL), 32'h0000_0001, 4'hF, ptoc_pkg::RESP_OKAY);
    repeat (140) @(posedge aclk);
    check_range({16'h0, rises[3]}, 32'h0000_0002, 32'h0000_0003);
    wr(ra(3, ptoc_pkg::REG_PERIOD), 32'h0000_0004, 4'hF, ptoc_pkg::RESP_OKAY);
    wr(ra(3, ptoc_pkg::REG_WIDTH), 32'h0000_0002, 4'hF, ptoc_pkg::RESP_OKAY);
    clear_load();
    repeat (40) @(posedge aclk);
    check_range({16'h0, rises[3]}, 32'h0000_0009, 32'h0000_000B);
    check_range({16'h0, highs[3]}, 32'h0000_0013, 32'h0000_0015);
    wr(ra(3, ptoc_pkg::REG_CTRL), 32'h0000_0000, 4'hF, ptoc_pkg::RESP_OKAY);
    repeat (3) @(posedge aclk);
    check_word({31'h0, pins[3]}, 32'h0000_0000);
  endtask

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  initial begin
    aresetn = 1'b0;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    clr = 1'b1;
    n_mismatch = 0;
    check_count = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    clr <= 1'b0;
    @(posedge aclk);
    t_reset();
    t_unmapped();
    t_count_width();
    t_delay();
    t_invert();
    t_clamp_live();
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    stop_test();
  end
endmodule // tb_pwm_timer_output_channels
`default_nettype wire
